// ===== common/tmc_pkg.sv
// Constants shared by the multithreading control instruction unit
package tmc_pkg;

    // -------------------------------------------------------------------
    // Instruction encodings
    // -------------------------------------------------------------------
    localparam logic [5:0] OPC_COP0          = 6'h10;
    localparam logic [5:0] OPC_SPECIAL_THREE = 6'h1F;
    localparam logic [5:0] FUNC_FORK         = 6'h08;
    localparam logic [4:0] MT_CTL_SUBOP      = 5'h0B;
    localparam logic [4:0] THR_CTL_RD        = 5'h01;
    localparam logic [4:0] THR_CTL_SEL       = 5'h0F;
    localparam logic [4:0] VP_CTL_RD         = 5'h00;
    localparam logic [4:0] VP_CTL_SEL        = 5'h00;
    localparam logic [4:0] FIELD_ZERO        = 5'h00;
    localparam logic [1:0] CTL_MID_ZERO      = 2'h0;
    localparam logic [2:0] CTL_LOW_CODE      = 3'h1;

    // -------------------------------------------------------------------
    // Instruction field positions
    // -------------------------------------------------------------------
    localparam int OPC_LSB     = 26;
    localparam int SUB_LSB     = 21;
    localparam int RS_LSB      = 21;
    localparam int RT_LSB      = 16;
    localparam int RD_LSB      = 11;
    localparam int SH_LSB      = 6;
    localparam int SET_CLR_BIT = 5;
    localparam int MID_LSB     = 3;

    // -------------------------------------------------------------------
    // Control register fields and reset values
    // -------------------------------------------------------------------
    localparam int          THREADS_ON_BIT   = 15;
    localparam int          EXC_CAUSE_LSB    = 16;
    localparam logic [2:0]  EXC_OVERFLOW     = 3'h1;
    localparam logic [2:0]  EXC_NONE         = 3'h0;
    localparam int          MULTI_VPE_ON_BIT = 0;
    localparam logic [31:0] VPE_CTL_RST      = 32'h0000_0000;
    localparam logic [31:0] PROC_CTL_RST     = 32'h0000_0000;

    // -------------------------------------------------------------------
    // Thread status word fields and reset value
    // -------------------------------------------------------------------
    localparam int          ST_FPU_MODE_BIT  = 26;
    localparam int          ST_ZHI_LSB       = 21;
    localparam int          ST_ONE_BIT       = 20;
    localparam int          ST_DYN_ALLOC_BIT = 15;
    localparam int          ST_ZERO_BIT      = 14;
    localparam int          ST_ACT_BIT       = 13;
    localparam int          ST_PRIV_LSB      = 11;
    localparam int          ST_ZLO_LSB       = 8;
    localparam logic [31:0] TC_STATUS_RST    = 32'h0000_0000;
    localparam logic [31:0] TC_WORD_RST      = 32'h0000_0000;

endpackage

// ===== core/tmc_thread_ctl.sv
// Multithreading control instruction unit: thread/VPE enable and fork
`timescale 1ns/100ps

module tmc_thread_ctl
    import tmc_pkg::*;
#(
    parameter int N_TC       = 4,
    parameter int VPE_W      = 2,
    parameter bit MT_PRESENT = 1'b1
)
(
    input  wire logic                        REF_CLK_IN,
    input  wire logic                        RST_N_IN,
    input  wire logic                        INSTR_VALID_IN,
    input  wire logic [31:0]                 INSTR_IN,
    input  wire logic [31:0]                 RS_VAL_IN,
    input  wire logic [31:0]                 RT_VAL_IN,
    input  wire logic                        CP0_USABLE_IN,
    input  wire logic                        MASTER_VPE_IN,
    input  wire logic                        USER_LOCAL_PRESENT_IN,
    input  wire logic [VPE_W-1:0]            ISSUE_VPE_IN,
    input  wire logic                        ISSUE_FPU_MODE_IN,
    input  wire logic [1:0]                  ISSUE_PRIV_IN,
    input  wire logic [31:0]                 ISSUE_USER_LOCAL_IN,
    input  wire logic [N_TC-1:0][VPE_W-1:0]  TC_BIND_IN,
    input  wire logic [N_TC-1:0]             TC_HALT_IN,
    input  wire logic [N_TC-1:0]             TC_STATUS_WR_IN,
    input  wire logic [31:0]                 TC_STATUS_WDATA_IN,
    input  wire logic                        EXC_CAUSE_CLR_IN,
    output logic                             GPR_WR_EN_OUT,
    output logic [4:0]                       GPR_WR_IDX_OUT,
    output logic [31:0]                      GPR_WR_DATA_OUT,
    output logic                             NEW_GPR_WR_EN_OUT,
    output logic [$clog2(N_TC+1)-1:0]        NEW_TC_IDX_OUT,
    output logic [4:0]                       NEW_GPR_IDX_OUT,
    output logic [31:0]                      NEW_GPR_DATA_OUT,
    output logic                             EXC_COP_UNUSABLE_OUT,
    output logic                             EXC_RESERVED_OUT,
    output logic                             EXC_THREAD_OUT,
    output logic [31:0]                      VPE_CTL_OUT,
    output logic [31:0]                      PROC_CTL_OUT,
    output logic [N_TC-1:0][31:0]            TC_STATUS_OUT,
    output logic [N_TC-1:0][31:0]            TC_RESTART_OUT,
    output logic [N_TC-1:0][31:0]            TC_USER_LOCAL_OUT,
    output logic [N_TC-1:0]                  TC_ISSUE_OK_OUT
);

    localparam int IDX_W = $clog2(N_TC + 1);

    // ---------------------------------------------------------------------
    // State
    // ---------------------------------------------------------------------
    typedef struct packed
    {
        logic [31:0]            vpe_ctl;
        logic [31:0]            proc_ctl;
        logic [N_TC-1:0][31:0]  status;
        logic [N_TC-1:0][31:0]  restart;
        logic [N_TC-1:0][31:0]  ulocal;
        logic                   gpr_we;
        logic [4:0]             gpr_idx;
        logic [31:0]            gpr_data;
        logic                   new_we;
        logic [IDX_W-1:0]       new_tc;
        logic [4:0]             new_idx;
        logic [31:0]            new_data;
        logic                   exc_cu;
        logic                   exc_ri;
        logic                   exc_thr;
    } tmc_state_t;

    tmc_state_t state_ff;
    tmc_state_t nxt_state;

    // ---------------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------------
    logic [4:0]        f_rs;
    logic [4:0]        f_rt;
    logic [4:0]        f_rd;
    logic              set_clear_bit;
    logic              is_ctl_form;
    logic              is_thr_op;
    logic              is_vp_op;
    logic              is_fork;
    logic              is_ctl_op;
    logic [N_TC-1:0]   tc_free;
    logic              any_free;
    logic [IDX_W-1:0]  first_idx;

    assign f_rs   = INSTR_IN[RS_LSB +: 5];
    assign f_rt   = INSTR_IN[RT_LSB +: 5];
    assign f_rd   = INSTR_IN[RD_LSB +: 5];
    assign set_clear_bit = INSTR_IN[SET_CLR_BIT];

    // Shared coprocessor opcode and control sub-opcode for all four forms
    assign is_ctl_form = (INSTR_IN[OPC_LSB +: 6] == OPC_COP0)
                       && (INSTR_IN[SUB_LSB +: 5] == MT_CTL_SUBOP)
                       && (INSTR_IN[MID_LSB +: 2] == CTL_MID_ZERO)
                       && (INSTR_IN[2:0] == CTL_LOW_CODE);
    assign is_thr_op = is_ctl_form && (f_rd == THR_CTL_RD)
                       && (INSTR_IN[SH_LSB +: 5] == THR_CTL_SEL);
    assign is_vp_op  = is_ctl_form && (f_rd == VP_CTL_RD)
                       && (INSTR_IN[SH_LSB +: 5] == VP_CTL_SEL);
    assign is_ctl_op = is_thr_op || is_vp_op;
    assign is_fork   = (INSTR_IN[OPC_LSB +: 6] == OPC_SPECIAL_THREE)
                       && (INSTR_IN[SH_LSB +: 5] == FIELD_ZERO)
                       && (INSTR_IN[5:0] == FUNC_FORK);

    // Candidate contexts: bound here, allocatable, not halted, not active
    genvar gi;
    generate
        for (gi = 0; gi < N_TC; gi++)
        begin : g_tc
            assign tc_free[gi] = (TC_BIND_IN[gi] == ISSUE_VPE_IN)
                               && state_ff.status[gi][ST_DYN_ALLOC_BIT]
                               && !TC_HALT_IN[gi]
                               && !state_ff.status[gi][ST_ACT_BIT];
            // Activated contexts run only once threading is enabled
            assign TC_ISSUE_OK_OUT[gi] = state_ff.status[gi][ST_ACT_BIT]
                               && !TC_HALT_IN[gi]
                               && state_ff.vpe_ctl[THREADS_ON_BIT];
        end
    endgenerate

    // Lowest index wins
    always_comb
    begin
        first_idx = IDX_W'(0);
        for (int i = N_TC - 1; i >= 0; i--)
        begin
            if (tc_free[i])
            begin
                first_idx = IDX_W'(i);
            end
        end
    end

    assign any_free = |tc_free;

    // ---------------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------------
    always_comb
    begin
        nxt_state         = state_ff;
        nxt_state.gpr_we  = 1'b0;
        nxt_state.new_we  = 1'b0;
        nxt_state.exc_cu  = 1'b0;
        nxt_state.exc_ri  = 1'b0;
        nxt_state.exc_thr = 1'b0;

        for (int i = 0; i < N_TC; i++)
        begin
            if (TC_STATUS_WR_IN[i])
            begin
                nxt_state.status[i] = TC_STATUS_WDATA_IN;
            end
        end
        if (EXC_CAUSE_CLR_IN)
        begin
            nxt_state.vpe_ctl[EXC_CAUSE_LSB +: 3] = EXC_NONE;
        end

        if (INSTR_VALID_IN && (is_ctl_op || is_fork))
        begin
            if (!MT_PRESENT)
            begin
                nxt_state.exc_ri = 1'b1;
            end
            else if (is_ctl_op && !CP0_USABLE_IN)
            begin
                nxt_state.exc_cu = 1'b1;
            end
            else if (is_thr_op)
            begin
                // Read and update in one edge: nothing can split them
                nxt_state.gpr_we   = (f_rt != 5'h00);
                nxt_state.gpr_idx  = f_rt;
                nxt_state.gpr_data = state_ff.vpe_ctl;
                nxt_state.vpe_ctl[THREADS_ON_BIT] = set_clear_bit;
            end
            else if (is_vp_op)
            begin
                nxt_state.gpr_we   = (f_rt != 5'h00);
                nxt_state.gpr_idx  = f_rt;
                nxt_state.gpr_data = state_ff.proc_ctl;
                if (MASTER_VPE_IN)
                begin
                    nxt_state.proc_ctl[MULTI_VPE_ON_BIT] = set_clear_bit;
                end
            end
            else if (any_free)
            begin
                nxt_state.new_we   = 1'b1;
                nxt_state.new_tc   = first_idx;
                nxt_state.new_idx  = f_rd;
                nxt_state.new_data = RT_VAL_IN;
                // Start address is only stored; its faults surface in the new thread
                nxt_state.restart[first_idx] = RS_VAL_IN;
                if (USER_LOCAL_PRESENT_IN)
                begin
                    nxt_state.ulocal[first_idx] = ISSUE_USER_LOCAL_IN;
                end
                // Prior usable, media, exempt, impl and address-space fields kept
                nxt_state.status[first_idx] = state_ff.status[first_idx];
                nxt_state.status[first_idx][ST_FPU_MODE_BIT]  = ISSUE_FPU_MODE_IN;
                nxt_state.status[first_idx][ST_ZHI_LSB +: 5]  = 5'h00;
                nxt_state.status[first_idx][ST_ONE_BIT]       = 1'b1;
                nxt_state.status[first_idx][ST_DYN_ALLOC_BIT] = 1'b1;
                nxt_state.status[first_idx][ST_ZERO_BIT]      = 1'b0;
                nxt_state.status[first_idx][ST_ACT_BIT]       = 1'b1;
                nxt_state.status[first_idx][ST_PRIV_LSB +: 2] = ISSUE_PRIV_IN;
                nxt_state.status[first_idx][ST_ZLO_LSB +: 2]  = 2'h0;
            end
            else
            begin
                // Overflow touches only the cause field; set beats a clear
                nxt_state.exc_thr = 1'b1;
                nxt_state.vpe_ctl[EXC_CAUSE_LSB +: 3] = EXC_OVERFLOW;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state_ff          <= '0;
            state_ff.vpe_ctl  <= VPE_CTL_RST;
            state_ff.proc_ctl <= PROC_CTL_RST;
            state_ff.status   <= {N_TC{TC_STATUS_RST}};
            state_ff.restart  <= {N_TC{TC_WORD_RST}};
            state_ff.ulocal   <= {N_TC{TC_WORD_RST}};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ---------------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------------
    assign GPR_WR_EN_OUT        = state_ff.gpr_we;
    assign GPR_WR_IDX_OUT       = state_ff.gpr_idx;
    assign GPR_WR_DATA_OUT      = state_ff.gpr_data;
    assign NEW_GPR_WR_EN_OUT    = state_ff.new_we;
    assign NEW_TC_IDX_OUT       = state_ff.new_tc;
    assign NEW_GPR_IDX_OUT      = state_ff.new_idx;
    assign NEW_GPR_DATA_OUT     = state_ff.new_data;
    assign EXC_COP_UNUSABLE_OUT = state_ff.exc_cu;
    assign EXC_RESERVED_OUT     = state_ff.exc_ri;
    assign EXC_THREAD_OUT       = state_ff.exc_thr;
    assign VPE_CTL_OUT          = state_ff.vpe_ctl;
    assign PROC_CTL_OUT         = state_ff.proc_ctl;
    assign TC_STATUS_OUT        = state_ff.status;
    assign TC_RESTART_OUT       = state_ff.restart;
    assign TC_USER_LOCAL_OUT    = state_ff.ulocal;

    // ---------------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic go_thr;
    logic go_vp;
    logic go_fork;
    assign go_thr  = INSTR_VALID_IN && MT_PRESENT && CP0_USABLE_IN && is_thr_op;
    assign go_vp   = INSTR_VALID_IN && MT_PRESENT && CP0_USABLE_IN && is_vp_op;
    assign go_fork = INSTR_VALID_IN && MT_PRESENT && is_fork;

    a_thr_old_value: assert property (go_thr && (f_rt != 5'h00) |=>
        GPR_WR_EN_OUT && (GPR_WR_DATA_OUT == $past(VPE_CTL_OUT)))
        else $error("old per-VPE control not returned");
    a_thr_enable_bit: assert property (go_thr |=>
        VPE_CTL_OUT[THREADS_ON_BIT] == $past(set_clear_bit))
        else $error("threads_on not taken from set_clear_bit");
    a_zero_dest: assert property ((go_thr || go_vp) && (f_rt == 5'h00) |=>
        !GPR_WR_EN_OUT)
        else $error("write to register zero issued");
    a_cop_unusable: assert property (INSTR_VALID_IN && MT_PRESENT && is_ctl_op && !CP0_USABLE_IN |=>
        EXC_COP_UNUSABLE_OUT && !GPR_WR_EN_OUT && $stable(PROC_CTL_OUT))
        else $error("coprocessor unusable case mishandled");
    a_reserved_op: assert property (INSTR_VALID_IN && !MT_PRESENT && (is_ctl_op || is_fork) |=>
        EXC_RESERVED_OUT && !NEW_GPR_WR_EN_OUT)
        else $error("reserved instruction not raised");
    a_vp_master_only: assert property (go_vp && !MASTER_VPE_IN |=>
        $stable(PROC_CTL_OUT) && (GPR_WR_DATA_OUT == $past(PROC_CTL_OUT)))
        else $error("non-master changed multi_vpe_on");
    a_vp_enable_bit: assert property (go_vp && MASTER_VPE_IN |=>
        PROC_CTL_OUT[MULTI_VPE_ON_BIT] == $past(set_clear_bit))
        else $error("multi_vpe_on not updated on master");
    a_fork_first_free: assert property (go_fork && any_free |=>
        NEW_GPR_WR_EN_OUT && (NEW_TC_IDX_OUT == $past(first_idx))
        && TC_STATUS_OUT[NEW_TC_IDX_OUT][ST_ACT_BIT])
        else $error("fork picked wrong context");
    a_fork_restart: assert property (go_fork && any_free |=>
        (TC_RESTART_OUT[NEW_TC_IDX_OUT] == $past(RS_VAL_IN))
        && (NEW_GPR_DATA_OUT == $past(RT_VAL_IN)))
        else $error("fork restart or value mismatch");
    a_fork_overflow: assert property (go_fork && !any_free && !EXC_CAUSE_CLR_IN
        && (TC_STATUS_WR_IN == '0) |=>
        EXC_THREAD_OUT && !NEW_GPR_WR_EN_OUT && $stable(TC_STATUS_OUT)
        && $stable(TC_RESTART_OUT) && (VPE_CTL_OUT[EXC_CAUSE_LSB +: 3] == EXC_OVERFLOW))
        else $error("fork overflow mishandled");
    a_issue_gate: assert property (|TC_ISSUE_OK_OUT |->
        VPE_CTL_OUT[THREADS_ON_BIT])
        else $error("context issues with threading off");

    c_thr_enable: cover property (go_thr && set_clear_bit ##1 GPR_WR_EN_OUT);
    c_vp_enable: cover property (go_vp && MASTER_VPE_IN && set_clear_bit);
    c_fork_ok: cover property (go_fork && any_free ##1 NEW_GPR_WR_EN_OUT);
    c_fork_overflow: cover property (go_fork && !any_free ##1 EXC_THREAD_OUT);

endmodule

// ===== sim/testbench.sv
// Self-checking testbench for the multithreading control instruction unit
`timescale 1ns/100ps
module testbench
    import tmc_pkg::*;
;
    logic             clk = 1'b0, rst_n = 1'b0, vld = 1'b0, cp0 = 1'b1, mst = 1'b1, ulp = 1'b1, clr = 1'b0;
    logic [31:0]      instr = '0, rs_v = '0, rt_v = '0, wd = '0;
    logic [3:0]       wr = '0;
    logic [3:0]       halt = 4'h2;
    logic [3:0][1:0]  bind_v = {2'h1, 2'h1, 2'h1, 2'h2};
    logic             gpr_en, nen, e_cop, e_res, e_thr;
    logic             ri_res, ri_gpr, ri_new;
    logic [4:0]       gpr_idx, nidx;
    logic [2:0]       ntc;
    logic [31:0]      gpr_dat, ndat, vctl_o, pctl_o;
    logic [3:0][31:0] st_o, rs_o, ul_o;
    logic [3:0]       iss_o;
    logic [31:0]      vctl = '0, pctl = '0;
    logic [31:0]      st [4], rsm [4], ulm [4];
    logic [44:0]      q [$];
    int               failures = 0, checks = 0, seed = 70, ri_seen = 0, ri_ops = 0;

    tmc_thread_ctl i_dut (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld), .INSTR_IN(instr),
        .RS_VAL_IN(rs_v), .RT_VAL_IN(rt_v), .CP0_USABLE_IN(cp0), .MASTER_VPE_IN(mst),
        .USER_LOCAL_PRESENT_IN(ulp), .ISSUE_VPE_IN(2'h1), .ISSUE_FPU_MODE_IN(rs_v[0]),
        .ISSUE_PRIV_IN(rt_v[1:0]), .ISSUE_USER_LOCAL_IN(~rt_v), .TC_BIND_IN(bind_v), .TC_HALT_IN(halt),
        .TC_STATUS_WR_IN(wr), .TC_STATUS_WDATA_IN(wd), .EXC_CAUSE_CLR_IN(clr),
        .GPR_WR_EN_OUT(gpr_en), .GPR_WR_IDX_OUT(gpr_idx), .GPR_WR_DATA_OUT(gpr_dat),
        .NEW_GPR_WR_EN_OUT(nen), .NEW_TC_IDX_OUT(ntc), .NEW_GPR_IDX_OUT(nidx), .NEW_GPR_DATA_OUT(ndat),
        .EXC_COP_UNUSABLE_OUT(e_cop), .EXC_RESERVED_OUT(e_res), .EXC_THREAD_OUT(e_thr),
        .VPE_CTL_OUT(vctl_o), .PROC_CTL_OUT(pctl_o), .TC_STATUS_OUT(st_o), .TC_RESTART_OUT(rs_o),
        .TC_USER_LOCAL_OUT(ul_o), .TC_ISSUE_OK_OUT(iss_o)
    );

    // Same stimulus into a unit built without the extension
    tmc_thread_ctl #(.N_TC(4), .VPE_W(2), .MT_PRESENT(1'b0)) i_dut_nomt (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld), .INSTR_IN(instr),
        .RS_VAL_IN(rs_v), .RT_VAL_IN(rt_v), .CP0_USABLE_IN(cp0), .MASTER_VPE_IN(mst),
        .USER_LOCAL_PRESENT_IN(ulp), .ISSUE_VPE_IN(2'h1), .ISSUE_FPU_MODE_IN(rs_v[0]),
        .ISSUE_PRIV_IN(rt_v[1:0]), .ISSUE_USER_LOCAL_IN(~rt_v), .TC_BIND_IN(bind_v), .TC_HALT_IN(halt),
        .TC_STATUS_WR_IN(wr), .TC_STATUS_WDATA_IN(wd), .EXC_CAUSE_CLR_IN(clr),
        .GPR_WR_EN_OUT(ri_gpr), .GPR_WR_IDX_OUT(), .GPR_WR_DATA_OUT(),
        .NEW_GPR_WR_EN_OUT(ri_new), .NEW_TC_IDX_OUT(), .NEW_GPR_IDX_OUT(), .NEW_GPR_DATA_OUT(),
        .EXC_COP_UNUSABLE_OUT(), .EXC_RESERVED_OUT(ri_res), .EXC_THREAD_OUT(),
        .VPE_CTL_OUT(), .PROC_CTL_OUT(), .TC_STATUS_OUT(), .TC_RESTART_OUT(),
        .TC_USER_LOCAL_OUT(), .TC_ISSUE_OK_OUT()
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Checking, drivers and reference model
    // ---------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Event word: kind {gpr, new gpr, cop, reserved, thread}, index, data, new context
    function automatic logic [44:0] ev(input logic [4:0] k, input logic [4:0] i, input logic [31:0] d,
                                       input logic [2:0] t);
        return {k, i, d, t};
    endfunction

    always @(negedge clk)
        if (rst_n && (gpr_en | nen | e_cop | e_res | e_thr))
            check(ev({gpr_en, nen, e_cop, e_res, e_thr}, gpr_en ? gpr_idx : nen ? nidx : 5'h0,
                     gpr_en ? gpr_dat : nen ? ndat : 32'h0, nen ? ntc : 3'h0),
                  q.size() ? q.pop_front() : 64'bx);

    // Reserved exceptions of the reduced unit, with no register write beside them
    always @(negedge clk)
        if (rst_n && ri_res && !ri_gpr && !ri_new)
            ri_seen++;

    task automatic drive(input logic v, input logic [31:0] w, s, t, input logic m, c, u,
                         input logic [3:0] wv, input logic [31:0] wdv, input logic cl);
        @(posedge clk);
        #1;
        {vld, instr, rs_v, rt_v, mst, cp0, ulp, wr, wd, clr} = {v, w, s, t, m, c, u, wv, wdv, cl};
        if (v)
            ri_ops++;
    endtask

    task automatic idle;
        drive(0, 0, 0, 0, 1, 1, 1, 0, 0, 0);
    endtask

    task automatic ctl(input logic th, en, input logic [4:0] rt, input logic m, c);
        logic [31:0] old;
        old = th ? vctl : pctl;
        if (!c)
            q.push_back(ev(5'h04, 0, 0, 0));
        else
        begin
            if (rt != 5'h0)
                q.push_back(ev(5'h10, rt, old, 0));
            if (th)
                vctl[THREADS_ON_BIT] = en;
            else if (m)
                pctl[MULTI_VPE_ON_BIT] = en;
        end
        drive(1, {OPC_COP0, MT_CTL_SUBOP, rt, th ? THR_CTL_RD : VP_CTL_RD, th ? THR_CTL_SEL : VP_CTL_SEL, en,
                  CTL_MID_ZERO, CTL_LOW_CODE}, $random(seed), $random(seed), m, c, 1, 0, 0, 0);
    endtask

    task automatic fork_op(input logic [4:0] rd, input logic u);
        logic [31:0] s;
        logic [31:0] t;
        int          pick;
        s = $random(seed);
        t = $random(seed);
        pick = -1;
        for (int i = 3; i >= 0; i--)
            if (bind_v[i] == 2'h1 && st[i][ST_DYN_ALLOC_BIT] && !halt[i] && !st[i][ST_ACT_BIT])
                pick = i;
        if (pick < 0)
        begin
            q.push_back(ev(5'h01, 0, 0, 0));
            vctl[EXC_CAUSE_LSB +: 3] = EXC_OVERFLOW;
        end
        else
        begin
            q.push_back(ev(5'h08, rd, t, 3'(pick)));
            rsm[pick] = s;
            if (u)
                ulm[pick] = ~t;
            st[pick] = (st[pick] & 32'hF80004FF) | 32'h0010A000 | (32'(s[0]) << ST_FPU_MODE_BIT)
                       | (32'(t[1:0]) << ST_PRIV_LSB);
        end
        drive(1, {OPC_SPECIAL_THREE, 5'h3, 5'h4, rd, FIELD_ZERO, FUNC_FORK}, s, t, 1, 1, u, 0, 0, 0);
    endtask

    task automatic wr_st(input int i, input logic [31:0] v);
        st[i] = v;
        drive(0, 0, 0, 0, 1, 1, 1, 4'(1 << i), v, 0);
    endtask

    task automatic chk;
        check(vctl_o, vctl);
        check(pctl_o, pctl);
        for (int i = 0; i < 4; i++)
        begin
            check(st_o[i] & 32'hFFF0FFFF, st[i] & 32'hFFF0FFFF);
            check(rs_o[i], rsm[i]);
            check(ul_o[i], ulm[i]);
            check(iss_o[i], st[i][ST_ACT_BIT] & !halt[i] & vctl[THREADS_ON_BIT]);
        end
    endtask

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 4; i++)
            {st[i], rsm[i], ulm[i]} = '0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        chk;
        ctl(1, 1, 5'h5, 1, 1);
        ctl(1, 0, 5'h0, 1, 1);
        ctl(1, 1, 5'h7, 1, 1);
        ctl(0, 1, 5'h3, 1, 1);
        ctl(0, 0, 5'h4, 0, 1);
        // An idle cycle stands in for the barrier before control reads
        idle;
        chk;
        ctl(0, 0, 5'h2, 1, 1);
        ctl(1, 0, 5'h6, 1, 0);
        idle;
        chk;
        for (int i = 0; i < 4; i++)
            wr_st(i, ($random(seed) & 32'hF80004FF) | 32'h00108000);
        ctl(1, 1, 5'h0, 1, 1);
        fork_op(5'h9, 1);
        fork_op(5'h1F, 0);
        fork_op(5'h2, 1);
        idle;
        chk;
        vctl[EXC_CAUSE_LSB +: 3] = EXC_NONE;
        drive(0, 0, 0, 0, 1, 1, 1, 0, 0, 1);
        wr_st(2, st[2] & ~(32'h1 << ST_ACT_BIT));
        fork_op(5'h1, 1);
        idle;
        chk;
        // Halting a context, then threading off, must stop issue of active contexts
        halt = 4'hA;
        idle;
        chk;
        ctl(1, 0, 5'h8, 1, 1);
        idle;
        chk;
        repeat (2) @(posedge clk);
        check(q.size(), 0);
        check(ri_seen, ri_ops);
        end_sim;
    end

    initial
    begin
        #20000;
        failures++;
        end_sim;
    end
endmodule
